/* hw/wd_lp_pkg.sv */
package wd_lp_pkg;

   // ---------------------------------------------
   // Low-power modes
   // ---------------------------------------------
   typedef enum logic [1:0] {LP_RUN, LP_IDLE, LP_STANDBY, LP_HALT} lp_state_t;

   localparam logic [1:0] SEL_IDLE    = 2'h0;
   localparam logic [1:0] SEL_STANDBY = 2'h1;

   // ---------------------------------------------
   // Watchdog
   // ---------------------------------------------
   localparam int         WD_WIDTH          = 8;
   localparam logic [7:0] WD_MAX            = 8'hff;
   localparam logic [7:0] KEY_FIRST         = 8'h55;
   localparam logic [7:0] KEY_SECOND        = 8'haa;
   localparam logic [9:0] WD_PULSE_CYCLES   = 10'h200;
   localparam logic [4:0] LOSS_RESET_CYCLES = 5'h10;
   localparam logic [1:0] WAKE_RECOG_CYCLES = 2'h2;
   localparam int         QUAL_WIDTH        = 6;
   localparam int         GPIO_WIDTH        = 32;

   // ---------------------------------------------
   // Controller register map (byte addresses)
   // ---------------------------------------------
   localparam logic [7:0] REG_WD_CTRL   = 8'h00;
   localparam logic [7:0] REG_WD_KEY    = 8'h04;
   localparam logic [7:0] REG_LP_CTRL   = 8'h08;
   localparam logic [7:0] REG_WAKE_SEL  = 8'h0c;
   localparam logic [7:0] REG_STATUS    = 8'h10;

   localparam int WD_CTRL_DISABLE  = 0;
   localparam int WD_CTRL_IRQ_MODE = 1;
   localparam int WD_CTRL_WAKE_EN  = 2;
   localparam int LP_CTRL_QUAL_LSB = 2;
   localparam int LP_CTRL_ENTER    = 31;
   localparam int STATUS_FLAG      = 8;
   localparam int STATUS_STATE_LSB = 9;
   localparam int STATUS_RESET_N   = 11;
   localparam int STATUS_WATCHDOG_WAKE_INTERRUPT_N   = 12;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hw/wd_lp_if.sv */
`timescale 1ns/1ps
interface wd_lp_if;
   // Orders from controller to device
   logic                         key_wr;
   logic [7:0]                   key_data;
   logic                         wd_disable;
   logic                         wd_irq_mode;
   logic                         wd_wake_enable;
   logic [1:0]                   low_power_select_field;
   logic                         lp_enter;
   logic [wd_lp_pkg::QUAL_WIDTH-1:0] qual_count;
   logic [wd_lp_pkg::GPIO_WIDTH-1:0] wake_pin_select;
   logic                         flag_clear;
   // Status from device to controller
   logic [7:0]                   wd_count;
   logic                         missing_clock_flag;
   wd_lp_pkg::lp_state_t         lp_state;
   logic                         device_reset_n;
   logic                         watchdog_wake_interrupt_n;

   modport ctl (output key_wr, key_data, wd_disable, wd_irq_mode, wd_wake_enable,
                low_power_select_field, lp_enter, qual_count, wake_pin_select, flag_clear,
                input wd_count, missing_clock_flag, lp_state, device_reset_n,
                watchdog_wake_interrupt_n);
   modport dev (input key_wr, key_data, wd_disable, wd_irq_mode, wd_wake_enable,
                low_power_select_field, lp_enter, qual_count, wake_pin_select, flag_clear,
                output wd_count, missing_clock_flag, lp_state, device_reset_n,
                watchdog_wake_interrupt_n);
endinterface

/* hw/wd_lp_device.sv */
// Functional notes
// RULE1: Limp clock feeds CPU on oscillator loss
// RULE2: Limp only after oscillator once present
// RULE3: Bypass mode auto-switches CPU to limp
// RULE4: Watchdog counter freezes while clock lost
// RULE5: Clock loss resets device, sets flag
// RULE6: Counter maximum drives 512-cycle low pulse
// RULE7: Software writes 0x55 then 0xAA
// RULE8: Disable control suppresses any timeout
// RULE9: Only watchdog runs in standby
// RULE10: Watchdog interrupt wakes device from standby
// RULE11: Watchdog interrupt reaches CPU in idle
// RULE12: Select 00 enters idle, clocks run
// RULE13: System clock stays on in idle
// RULE14: Idle exits on reset, watchdog, interrupt, NMI
// RULE15: Select 01 enters standby, CPU clocks stop
// RULE16: Standby exits on reset, watchdog, GPIO, debug, NMI
// RULE17: Selected GPIO qualified for programmed cycles
// RULE18: Select 1X enters halt, everything stops
// RULE19: Halt exits on reset, GPIO, NMI, debug
// RULE20: Wake signals low, held until recognised
// RULE21: Output pins hold through low-power modes
// RULE22: Debug port works with CPU clock stopped
// RULE23: Only 0xAA right after 0x55 clears
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module wd_lp_device
(
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Controller side
   wd_lp_if.dev                       ctl,
   // Clock source status
   input  wire logic                  oscillator_ok,
   input  wire logic                  pll_bypass,
   output logic                       limp_clock_select,
   output logic                       cpu_clock_from_limp,
   // Wake and reset pins, active low
   input  wire logic                  external_reset_pin_n,
   input  wire logic                  external_nmi_input_n,
   input  wire logic                  enabled_irq_n,
   input  wire logic                  debug_request_n,
   input  wire logic [31:0]           gpio_port_a,
   // Clock gates and CPU interrupt
   output logic                       cpu_clock_in_en,
   output logic                       system_clock_out_en,
   output logic                       peripheral_clock_en,
   output logic                       oscillator_en,
   output logic                       debug_port_en,
   output logic                       wd_cpu_irq,
   // Output pins
   input  wire logic [15:0]           pin_drive,
   output logic [15:0]                pin_out
);

   wd_lp_pkg::lp_state_t              state;
   logic                              osc_seen;
   logic                              clock_lost;
   logic                              clock_lost_d;
   logic [4:0]                        loss_rst_cnt;
   logic [7:0]                        wd_cnt;
   logic [9:0]                        pulse_cnt;
   logic                              pulse_active;
   logic                              key_armed;
   logic                              wd_run;
   logic                              ext_rst;
   logic                              gpio_low;
   logic [wd_lp_pkg::QUAL_WIDTH-1:0]  qual_cnt;
   logic                              gpio_qualified;
   logic                              wd_int_low;
   logic                              wake_level;
   logic [1:0]                        wake_cnt;
   logic                              wake_now;

   // ---------------------------------------------
   // Clock loss
   // ---------------------------------------------
   assign ext_rst    = !external_reset_pin_n;
   assign clock_lost = osc_seen && !oscillator_ok; // RULE2

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         osc_seen <= 1'b0;
      else if (oscillator_ok)
         osc_seen <= 1'b1;
   end

   // Limp clock is the PLL output; both PLL modes route it when the input dies
   assign limp_clock_select   = clock_lost; // RULE1
   assign cpu_clock_from_limp = clock_lost && (pll_bypass || osc_seen); // RULE3

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clock_lost_d <= 1'b0;
      else
         clock_lost_d <= clock_lost;
   end

   // Loss reset runs on the limp clock, so it still counts
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         loss_rst_cnt <= 5'h00;
      else if (clock_lost && !clock_lost_d)
         loss_rst_cnt <= wd_lp_pkg::LOSS_RESET_CYCLES; // RULE5
      else if (loss_rst_cnt != 5'h00)
         loss_rst_cnt <= loss_rst_cnt - 5'h01;
   end

   // Set wins over clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctl.missing_clock_flag <= 1'b0;
      else if (clock_lost && !clock_lost_d)
         ctl.missing_clock_flag <= 1'b1; // RULE5
      else if (ctl.flag_clear)
         ctl.missing_clock_flag <= 1'b0;
   end

   // ---------------------------------------------
   // Watchdog
   // ---------------------------------------------
   assign wd_run = oscillator_ok && !clock_lost && (state != wd_lp_pkg::LP_HALT); // RULE4 RULE18

   always_ff @(posedge aclk)
   begin
      if (!aresetn || ext_rst)
         key_armed <= 1'b0;
      else if (ctl.key_wr)
         key_armed <= (ctl.key_data == wd_lp_pkg::KEY_FIRST); // RULE23
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || ext_rst)
         wd_cnt <= 8'h00;
      else if (ctl.key_wr && key_armed && ctl.key_data == wd_lp_pkg::KEY_SECOND)
         wd_cnt <= 8'h00; // RULE7 RULE23
      else if (wd_run && !ctl.wd_disable && !pulse_active) // RULE8 RULE9
         wd_cnt <= (wd_cnt == wd_lp_pkg::WD_MAX) ? 8'h00 : wd_cnt + 8'h01;
   end

   // Pulse width counts oscillator cycles only, frozen like the counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ext_rst)
         pulse_cnt <= 10'h000;
      else if (wd_run && !ctl.wd_disable && !pulse_active && wd_cnt == wd_lp_pkg::WD_MAX)
         pulse_cnt <= wd_lp_pkg::WD_PULSE_CYCLES; // RULE6 RULE8
      else if (wd_run && pulse_active)
         pulse_cnt <= pulse_cnt - 10'h001; // RULE4
   end

   assign pulse_active                  = (pulse_cnt != 10'h000);
   assign wd_int_low                    = pulse_active && ctl.wd_irq_mode;
   assign ctl.watchdog_wake_interrupt_n = !wd_int_low;
   assign ctl.wd_count                  = wd_cnt;
   assign ctl.device_reset_n = !(pulse_active && !ctl.wd_irq_mode) // RULE6
                               && (loss_rst_cnt == 5'h00) && !ext_rst; // RULE5
   assign wd_cpu_irq = wd_int_low && (state == wd_lp_pkg::LP_IDLE || state == wd_lp_pkg::LP_RUN); // RULE11

   // ---------------------------------------------
   // Wake qualification
   // ---------------------------------------------
   assign gpio_low = |(~gpio_port_a & ctl.wake_pin_select); // RULE17 RULE20

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !gpio_low)
         qual_cnt <= '0;
      else if (qual_cnt != ctl.qual_count)
         qual_cnt <= qual_cnt + 1'b1;
   end

   assign gpio_qualified = gpio_low && (qual_cnt == ctl.qual_count); // RULE17

   always_comb
   begin
      case (state)
         wd_lp_pkg::LP_IDLE:
            wake_level = ext_rst || wd_int_low || !enabled_irq_n
                         || !external_nmi_input_n; // RULE14
         wd_lp_pkg::LP_STANDBY:
            wake_level = ext_rst || (wd_int_low && ctl.wd_wake_enable) // RULE10 RULE16
                         || gpio_qualified || !debug_request_n || !external_nmi_input_n;
         // Oscillator is off in halt, so no qualification is possible there
         wd_lp_pkg::LP_HALT:
            wake_level = ext_rst || gpio_low || !external_nmi_input_n
                         || !debug_request_n; // RULE19
         default:
            wake_level = 1'b0;
      endcase
   end

   // A short glitch drops the count and the mode is kept
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !wake_level)
         wake_cnt <= 2'h0;
      else if (!wake_now)
         wake_cnt <= wake_cnt + 2'h1; // RULE20
   end

   assign wake_now = wake_level && (wake_cnt == wd_lp_pkg::WAKE_RECOG_CYCLES - 2'h1);

   // ---------------------------------------------
   // Low-power state
   // ---------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ext_rst)
         state <= wd_lp_pkg::LP_RUN;
      else
         case (state)
            wd_lp_pkg::LP_RUN:
               if (ctl.lp_enter)
               begin
                  if (ctl.low_power_select_field[1])
                     state <= wd_lp_pkg::LP_HALT; // RULE18
                  else if (ctl.low_power_select_field == wd_lp_pkg::SEL_STANDBY)
                     state <= wd_lp_pkg::LP_STANDBY; // RULE15
                  else
                     state <= wd_lp_pkg::LP_IDLE; // RULE12
               end
            default:
               if (wake_now)
                  state <= wd_lp_pkg::LP_RUN;
         endcase
   end

   assign ctl.lp_state = state;

   // Idle keeps every clock; standby keeps only the oscillator, watchdog and debug port
   assign cpu_clock_in_en     = (state == wd_lp_pkg::LP_RUN) || (state == wd_lp_pkg::LP_IDLE); // RULE12 RULE15
   assign system_clock_out_en = cpu_clock_in_en; // RULE13
   assign peripheral_clock_en = cpu_clock_in_en; // RULE9
   assign oscillator_en       = (state != wd_lp_pkg::LP_HALT); // RULE18
   // Debug logic sits outside the CPU clock gate
   assign debug_port_en       = aresetn; // RULE22

   // ---------------------------------------------
   // Output pins
   // ---------------------------------------------
   // Pins only follow software while running; they freeze otherwise
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pin_out <= 16'h0000;
      else if (state == wd_lp_pkg::LP_RUN && !ctl.lp_enter)
         pin_out <= pin_drive; // RULE21
   end

endmodule // wd_lp_device

/* hw/wd_lp_ctrl.sv */
`timescale 1ns/1ps
module wd_lp_ctrl
(
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Device side
   wd_lp_if.ctl               dev,
   // AXI4-Lite write
   input  wire logic [7:0]    awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   // AXI4-Lite read
   input  wire logic [7:0]    araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready
);

   logic                      aw_held;
   logic                      w_held;
   logic [7:0]                wr_addr;
   logic [31:0]               wr_data;
   logic [3:0]                wr_strb;
   logic                      do_write;
   logic [31:0]               status;

   // ---------------------------------------------
   // Write channel
   // ---------------------------------------------
   assign awready  = !aw_held && !bvalid;
   assign wready   = !w_held && !bvalid;
   assign do_write = aw_held && w_held && !bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         wr_addr <= 8'h00;
      end
      else if (awvalid && awready)
      begin
         aw_held <= 1'b1;
         wr_addr <= awaddr;
      end
      else if (do_write)
         aw_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held  <= 1'b0;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end
      else if (wvalid && wready)
      begin
         w_held  <= 1'b1;
         wr_data <= wdata;
         wr_strb <= wstrb;
      end
      else if (do_write)
         w_held <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= wd_lp_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp  <= (wr_addr > wd_lp_pkg::REG_STATUS || wr_addr[1:0] != 2'h0)
                   ? wd_lp_pkg::RESP_SLVERR : wd_lp_pkg::RESP_OKAY;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   // Only the low byte lane carries control bits, except wake select, enter and flag clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dev.wd_disable             <= 1'b0;
         dev.wd_irq_mode            <= 1'b0;
         dev.wd_wake_enable         <= 1'b0;
         dev.low_power_select_field <= wd_lp_pkg::SEL_IDLE;
         dev.qual_count             <= '0;
         dev.wake_pin_select        <= 32'h00000000;
      end
      else if (do_write && wr_strb[0] && wr_addr == wd_lp_pkg::REG_WD_CTRL)
      begin
         dev.wd_disable     <= wr_data[wd_lp_pkg::WD_CTRL_DISABLE];
         dev.wd_irq_mode    <= wr_data[wd_lp_pkg::WD_CTRL_IRQ_MODE];
         dev.wd_wake_enable <= wr_data[wd_lp_pkg::WD_CTRL_WAKE_EN];
      end
      else if (do_write && wr_strb[0] && wr_addr == wd_lp_pkg::REG_LP_CTRL)
      begin
         dev.low_power_select_field <= wr_data[1:0];
         dev.qual_count <= wr_data[wd_lp_pkg::LP_CTRL_QUAL_LSB +: wd_lp_pkg::QUAL_WIDTH];
      end
      else if (do_write && wr_strb == 4'hf && wr_addr == wd_lp_pkg::REG_WAKE_SEL)
         dev.wake_pin_select <= wr_data;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dev.key_wr     <= 1'b0;
         dev.key_data   <= 8'h00;
         dev.lp_enter   <= 1'b0;
         dev.flag_clear <= 1'b0;
      end
      else
      begin
         dev.key_wr     <= do_write && wr_strb[0] && wr_addr == wd_lp_pkg::REG_WD_KEY;
         dev.key_data   <= wr_data[7:0];
         dev.lp_enter   <= do_write && wr_strb[3] && wr_addr == wd_lp_pkg::REG_LP_CTRL
                           && wr_data[wd_lp_pkg::LP_CTRL_ENTER];
         dev.flag_clear <= do_write && wr_strb[1] && wr_addr == wd_lp_pkg::REG_STATUS
                           && wr_data[wd_lp_pkg::STATUS_FLAG];
      end
   end

   // ---------------------------------------------
   // Read channel
   // ---------------------------------------------
   assign status = {19'h00000, !dev.watchdog_wake_interrupt_n == 1'b0, dev.device_reset_n,
                    dev.lp_state, dev.missing_clock_flag, dev.wd_count};
   assign arready = !rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= wd_lp_pkg::RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp  <= wd_lp_pkg::RESP_OKAY;
         case (araddr)
            wd_lp_pkg::REG_WD_CTRL:
               rdata <= {29'h00000000, dev.wd_wake_enable, dev.wd_irq_mode, dev.wd_disable};
            wd_lp_pkg::REG_WD_KEY:
               rdata <= 32'h00000000;
            wd_lp_pkg::REG_LP_CTRL:
               rdata <= {24'h000000, dev.qual_count, dev.low_power_select_field};
            wd_lp_pkg::REG_WAKE_SEL:
               rdata <= dev.wake_pin_select;
            wd_lp_pkg::REG_STATUS:
               rdata <= status;
            default:
            begin
               rdata <= 32'h00000000;
               rresp <= wd_lp_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (rready)
         rvalid <= 1'b0;
   end

endmodule // wd_lp_ctrl

/* tb/wd_lp_chk.sv */
`timescale 1ns/1ps
module wd_lp_chk
(
   // Clock and reset
   input wire logic                 aclk,
   input wire logic                 aresetn,
   // Link signals
   input wire logic                 key_wr,
   input wire logic [7:0]           key_data,
   input wire logic                 wd_disable,
   input wire logic [1:0]           low_power_select_field,
   input wire logic                 lp_enter,
   input wire logic                 flag_clear,
   input wire logic [7:0]           wd_count,
   input wire logic                 missing_clock_flag,
   input wire wd_lp_pkg::lp_state_t lp_state,
   input wire logic                 device_reset_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic        armed;
   logic        wd_pulse;
   logic [10:0] low_cnt;
   // ---------------------------------------------
   // Helper state
   // ---------------------------------------------
   always_ff @(posedge aclk)
      if (!aresetn) armed <= 1'b0;
      else if (key_wr) armed <= (key_data == 8'h55);
   always_ff @(posedge aclk)
      if (!aresetn || device_reset_n) low_cnt <= 11'h000;
      else low_cnt <= low_cnt + 11'h001;
   // Only a pulse that follows a full count is measured
   always_ff @(posedge aclk)
      if (!aresetn) wd_pulse <= 1'b0;
      else if ($fell(device_reset_n)) wd_pulse <= ($past(wd_count) == 8'hff);
      else if (device_reset_n) wd_pulse <= 1'b0;
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   sequence s_good_key;
      key_wr && key_data == 8'haa && armed;
   endsequence
   sequence s_bad_key;
      key_wr && key_data == 8'haa && !armed && wd_count != 8'h00 && wd_count != 8'hff;
   endsequence
   property p_key_clear;
      s_good_key ##1 device_reset_n |-> wd_count == 8'h00;
   endproperty
   property p_key_bad;
      s_bad_key ##1 device_reset_n |-> wd_count != 8'h00;
   endproperty
   property p_disable;
      (wd_disable && !key_wr) ##1 device_reset_n |-> $stable(wd_count);
   endproperty
   property p_pulse_len;
      $rose(device_reset_n) && wd_pulse |-> low_cnt == 11'h200;
   endproperty
   property p_pulse_bound;
      wd_pulse |-> low_cnt <= 11'h200;
   endproperty
   property p_idle;
      lp_enter && lp_state == wd_lp_pkg::LP_RUN && low_power_select_field == 2'h0
         |=> lp_state == wd_lp_pkg::LP_IDLE;
   endproperty
   property p_standby;
      lp_enter && lp_state == wd_lp_pkg::LP_RUN && low_power_select_field == 2'h1
         |=> lp_state == wd_lp_pkg::LP_STANDBY;
   endproperty
   property p_halt;
      lp_enter && lp_state == wd_lp_pkg::LP_RUN && low_power_select_field[1]
         |=> lp_state == wd_lp_pkg::LP_HALT;
   endproperty
   property p_flag;
      missing_clock_flag && !flag_clear |=> missing_clock_flag;
   endproperty
   a_key_clear: assert property (p_key_clear)
      else $error("key sequence did not clear counter");
   a_key_bad: assert property (p_key_bad)
      else $error("broken key sequence cleared counter");
   a_disable: assert property (p_disable)
      else $error("disabled counter moved");
   a_pulse_len: assert property (p_pulse_len)
      else $error("timeout pulse length wrong");
   a_pulse_bound: assert property (p_pulse_bound)
      else $error("timeout pulse too long");
   a_idle: assert property (p_idle)
      else $error("idle not entered");
   a_standby: assert property (p_standby)
      else $error("standby not entered");
   a_halt: assert property (p_halt)
      else $error("halt not entered");
   a_flag: assert property (p_flag)
      else $error("missing clock flag lost");
endmodule // wd_lp_chk

/* tb/watchdog_lowpower_clockfail_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      comparisons++; \
      if ((a) !== (b)) \
      begin \
         errors++; \
         $display("[FAIL] %0t got %0h expected %0h", $time, (a), (b)); \
      end \
   end
module watchdog_lowpower_clockfail_tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic oscillator_ok = 1'b0, pll_bypass = 1'b0, rst_pin_n = 1'b1, nmi_n = 1'b1;
   logic irq_n = 1'b1, dbg_n = 1'b1;
   logic [31:0] gpio = 32'hffffffff;
   logic [15:0] pin_drive = 16'h0, pin_out, p;
   logic limp_sel, cpu_limp, cpu_en, sys_en, per_en, osc_en, dbg_en, wd_cpu_irq;
   logic [7:0] c1, k;
   int errors = 0, comparisons = 0, n, b, m;
   always #50 aclk = ~aclk;
   wd_lp_if u_wd_lp_if ();
   wd_lp_ctrl u_wd_lp_ctrl (.aclk(aclk), .aresetn(aresetn), .dev(u_wd_lp_if), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   wd_lp_device u_wd_lp_device (.aclk(aclk), .aresetn(aresetn), .ctl(u_wd_lp_if),
      .oscillator_ok(oscillator_ok), .pll_bypass(pll_bypass), .limp_clock_select(limp_sel),
      .cpu_clock_from_limp(cpu_limp), .external_reset_pin_n(rst_pin_n),
      .external_nmi_input_n(nmi_n), .enabled_irq_n(irq_n), .debug_request_n(dbg_n),
      .gpio_port_a(gpio), .cpu_clock_in_en(cpu_en), .system_clock_out_en(sys_en),
      .peripheral_clock_en(per_en), .oscillator_en(osc_en), .debug_port_en(dbg_en),
      .wd_cpu_irq(wd_cpu_irq), .pin_drive(pin_drive), .pin_out(pin_out));
   wd_lp_chk u_wd_lp_chk (.aclk(aclk), .aresetn(aresetn), .key_wr(u_wd_lp_if.key_wr),
      .key_data(u_wd_lp_if.key_data), .wd_disable(u_wd_lp_if.wd_disable),
      .low_power_select_field(u_wd_lp_if.low_power_select_field),
      .lp_enter(u_wd_lp_if.lp_enter), .flag_clear(u_wd_lp_if.flag_clear),
      .wd_count(u_wd_lp_if.wd_count), .missing_clock_flag(u_wd_lp_if.missing_clock_flag),
      .lp_state(u_wd_lp_if.lp_state), .device_reset_n(u_wd_lp_if.device_reset_n));
   // ---------------------------------------------
   // Bus tasks and expectations
   // ---------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (awready && !ad)
         begin
            awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (wready && !wd)
         begin
            wvalid <= 1'b0;
            wd = 1'b1;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      rv = rdata;
      resp = rresp;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge aclk);
   endtask
   // Wake sources by mode: interrupt, gpio, nmi, debugger
   task automatic wake(input int m, input logic v);
      case (m)
         0: irq_n <= v;
         1: gpio[b] <= v;
         2: nmi_n <= v;
         default: dbg_n <= v;
      endcase
   endtask
   task automatic wait_run(input int lim);
      n = 0;
      while (u_wd_lp_if.lp_state !== wd_lp_pkg::LP_RUN && n < lim)
      begin
         @(posedge aclk);
         n++;
      end
   endtask
   function automatic wd_lp_pkg::lp_state_t exp_state(input logic [1:0] s);
      return s[1] ? wd_lp_pkg::LP_HALT : (s[0] ? wd_lp_pkg::LP_STANDBY : wd_lp_pkg::LP_IDLE);
   endfunction
   // Enables: cpu, system, peripheral, oscillator, debug
   function automatic logic [4:0] exp_en(input logic [1:0] s);
      return s[1] ? 5'h01 : (s[0] ? 5'h03 : 5'h1f);
   endfunction
   task automatic conclude;
      if (errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      cyc(20000);
      errors++;
      conclude();
   end
   initial
   begin
      n = $urandom(32'h83ae);
      cyc(12);
      aresetn <= 1'b1;
      cyc(4);
      `CHK(limp_sel, 1'b0)
      oscillator_ok <= 1'b1;
      b = $urandom % 32;
      k = 8'h80 | 8'($urandom);
      for (n = 0; u_wd_lp_if.device_reset_n && n < 300; n++) @(posedge aclk);
      `CHK(n < 300, 1'b1)
      cyc(520);
      wr(8'h04, 32'h55, 4'h1);
      wr(8'h04, 32'haa, 4'h1);
      rd(8'h10);
      `CHK(rv[7:0] < 8'h08, 1'b1)
      wr(8'h04, {24'h0, k}, 4'h1);
      wr(8'h04, 32'haa, 4'h1);
      wr(8'h00, 32'h1, 4'h1);
      rd(8'h10);
      c1 = rv[7:0];
      cyc(300);
      rd(8'h10);
      `CHK(rv[7:0], c1)
      wr(8'h0c, 32'h1 << b, 4'hf);
      for (int s = 0; s < 3; s++)
      begin
         m = (s == 2) ? 3 : s;
         p = 16'($urandom);
         pin_drive <= p;
         wr(8'h08, {1'b1, 23'h0, 6'h3, 2'(s)}, 4'h9);
         pin_drive <= ~p;
         wake(m, 1'b0);
         cyc(1);
         wake(m, 1'b1);
         cyc(3);
         `CHK(u_wd_lp_if.lp_state, exp_state(2'(s)))
         `CHK({cpu_en, sys_en, per_en, osc_en, dbg_en}, exp_en(2'(s)))
         `CHK(pin_out, p)
         wake(m, 1'b0);
         wait_run(20);
         wake(m, 1'b1);
         `CHK(n < 20, 1'b1)
      end
      wr(8'h00, 32'h0, 4'h1);
      oscillator_ok <= 1'b0;
      cyc(2);
      `CHK({limp_sel, cpu_limp}, 2'h3)
      c1 = u_wd_lp_if.wd_count;
      cyc(30);
      `CHK(u_wd_lp_if.wd_count, c1)
      rd(8'h10);
      `CHK(rv[8], 1'b1)
      wr(8'h10, 32'h100, 4'h2);
      rd(8'h10);
      `CHK(rv[8], 1'b0)
      conclude();
   end
endmodule // watchdog_lowpower_clockfail_tb
